// File: include/tbsps_pkg.sv
/*
  Package for the timebase steering and pulse-per-second block: widths,
  limits, divider counts, mode encodings and the command carrier struct.
  Assumes a 20 MHz system clock and a 10 MHz timebase sampled as a pin.
*/
package tbsps_pkg;

  // Steering in parts per 1e15, signed
  localparam int unsigned STEER_W         = 32;
  localparam logic signed [31:0] STEER_LIMIT = 32'sd20000000;
  // Hardware steer reported in parts per 1e12
  localparam logic signed [31:0] REPORT_DIV  = 32'sd1000;
  localparam logic signed [31:0] REPORT_HALF = 32'sd500;
  localparam int unsigned CAL_W           = 40;

  // Timebase frequency and pulse divider
  localparam int unsigned TB_FREQ_HZ      = 10000000;
  localparam int unsigned PPS_DIV         = 10000000;
  localparam int unsigned PPS_CNT_W       = 24;
  // Pulse high for half the period
  localparam logic [23:0] PPS_HIGH_TICKS  = 24'h4c4b40;
  localparam logic [23:0] PPS_LAST_TICK   = 24'h98967f;

  // Mode store reset values
  localparam logic MODE_AUTO_RST          = 1'b0;
  localparam logic MODE_DISC_RST          = 1'b0;

  typedef enum logic [1:0] {
    TBSPS_ALIGN_IDLE  = 2'b00,
    TBSPS_ALIGN_ARMED = 2'b01,
    TBSPS_ALIGN_AUTO  = 2'b10
  } tbsps_align_t;

  // One command from the host port: one strobe per command kind, plus mode_value and value data
  typedef struct packed {
    logic                      absolute_adjust_cmd;
    logic                      relative_adjust_cmd;
    logic                      calibration_commit_cmd;
    logic                      align_request;
    logic                      set_auto_align;
    logic                      set_discipline;
    logic                      mode_value;
    logic signed [31:0]        value;
  } tbsps_cmd_t;

endpackage

// File: src/tbsps_sync3.sv
/*
  Three-stage synchroniser for one pin level.
  Assumes the pin is asynchronous to clk; the change is accepted once the
  second and third stages agree.
*/
`timescale 1ns/10ps
module tbsps_sync3 #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Pin and clean level
  input  wire logic pin,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= RESET_VALUE;
      s2_q <= RESET_VALUE;
      s3_q <= RESET_VALUE;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Holds last agreed value while stages 2 and 3 differ
  always_ff @(posedge clk) begin
    if (!resetn) begin
      level <= RESET_VALUE;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule

// File: src/tbsps_core.sv
/*
  Timebase steering, calibration commit and pulse-per-second generator
  with manual and automatic alignment to a reference pulse.
  Assumes: clk at 20 MHz; the 10 MHz timebase and the reference pulse
  arrive as pins; the host presents commands as one-cycle strobes on the
  plain register port; the calibration and mode stores are held by the
  surrounding non-volatile memory and loaded through the nv ports.
*/
// Implementation choices: strobed register access and the placing of the registers.
// Notes on behaviour
// - Steer values are signed integers in parts per 1e15.
// - Absolute adjust replaces the held steer with the new value.
// - Relative adjust adds the new value to the held steer.
// - Each commanded value is clamped to plus or minus twenty million.
// - Running steer total saturates at plus or minus twenty million.
// - Steer kept at 1e15 resolution; report rounded to 1e12 units.
// - Steer clears at reset; calibrated value alone then applies.
// - Calibration commit adds the present steer into the calibration value.
// - Steer returns to zero right after a calibration commit.
// - Pulse output divides the 10 MHz timebase by ten million.
// - Pulse runs from reset without lock; rising edge is on time.
// - Each pulse edge sits on a rising timebase edge.
// - Alignment restarts the divider at the timebase edge nearest reference; the code uses the first timebase rising edge after it.
// - One mode bit picks manual or automatic alignment; kept across power.
// - Manual mode ignores the reference until the host asks to align.
// - After a request, align to the first following reference rising edge.
// - Automatic mode realigns on every reference rising edge.
// - Automatic alignment and disciplining exclude each other.
`timescale 1ns/10ps
module tbsps_core
  import tbsps_pkg::*;
#(
  parameter int unsigned PPS_DIVIDE = PPS_DIV
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Host register port
  input  wire logic [3:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  // Decoded command strobes
  input  wire tbsps_pkg::tbsps_cmd_t    cmd,
  // Non-volatile store image
  input  wire logic signed [39:0]       nv_cal_value,
  input  wire logic                     nv_auto_align,
  input  wire logic                     nv_discipline,
  output logic signed [39:0]            cal_value,
  output logic                          cal_write,
  output logic                          mode_auto_align,
  output logic                          mode_discipline,
  // Steering result
  output logic signed [31:0]            steer_total,
  output logic signed [31:0]            steer_report,
  // Timebase and pulses
  input  wire logic                     tb_clk_pin,
  input  wire logic                     ref_pps_pin,
  output logic                          pps_out,
  output logic                          align_done
);
  import tbsps_pkg::*;

  // Refused at elaboration: counter must hold the last tick
  if (PPS_DIVIDE < 4 || PPS_DIVIDE > (1 << PPS_CNT_W)) begin : g_bad_divide
    $error("PPS_DIVIDE out of range");
  end

  localparam logic [3:0] ADDR_STEER  = 4'h0;
  localparam logic [3:0] ADDR_REPORT = 4'h1;
  localparam logic [3:0] ADDR_MODE   = 4'h2;
  localparam logic [3:0] ADDR_CAL_LO = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [PPS_CNT_W-1:0] LAST_TICK = PPS_CNT_W'(PPS_DIVIDE - 1);
  localparam logic [PPS_CNT_W-1:0] HIGH_TICKS = PPS_CNT_W'(PPS_DIVIDE / 2);

  // Clamp a signed wide value to the steer range
  function automatic logic signed [31:0] clamp_steer(input logic signed [33:0] v);
    logic signed [33:0] lim;
    lim = 34'(STEER_LIMIT);
    if (v > lim) begin
      clamp_steer = STEER_LIMIT;
    end else if (v < -lim) begin
      clamp_steer = -STEER_LIMIT;
    end else begin
      clamp_steer = 32'(v);
    end
  endfunction

  // Register writes also act as commands, so the host may use either path
  tbsps_cmd_t c;
  always_comb begin
    c = cmd;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_STEER: begin
          c.absolute_adjust_cmd = 1'b1;
          c.value               = signed'(reg_wdata);
        end
        ADDR_REPORT: begin
          c.relative_adjust_cmd = 1'b1;
          c.value               = signed'(reg_wdata);
        end
        ADDR_MODE: begin
          c.calibration_commit_cmd = reg_wdata[4];
          c.align_request          = reg_wdata[3];
          c.set_auto_align         = reg_wdata[0];
          c.set_discipline         = reg_wdata[1];
          c.mode_value             = reg_wdata[2];
        end
        default: begin
        end
      endcase
    end
  end

  // Steering accumulator
  logic signed [31:0] steer_q;
  logic signed [31:0] cmd_clamped;
  logic signed [33:0] rel_sum;
  assign cmd_clamped = clamp_steer(34'(c.value));
  assign rel_sum     = 34'(steer_q) + 34'(cmd_clamped);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      steer_q <= '0;
    end else if (c.calibration_commit_cmd) begin
      steer_q <= '0;
    end else if (c.absolute_adjust_cmd) begin
      steer_q <= cmd_clamped;
    end else if (c.relative_adjust_cmd) begin
      steer_q <= clamp_steer(rel_sum);
    end
  end
  assign steer_total = steer_q;

  // Report rounded half away from zero in units of 1e12
  logic signed [31:0] report_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      report_q <= '0;
    end else if (steer_q < 0) begin
      report_q <= (steer_q - REPORT_HALF) / REPORT_DIV;
    end else begin
      report_q <= (steer_q + REPORT_HALF) / REPORT_DIV;
    end
  end
  assign steer_report = report_q;

  // Calibration value; the surrounding store limits wear, not this logic
  logic signed [39:0] cal_q;
  logic               cal_loaded_q;
  logic               cal_write_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cal_q        <= '0;
      cal_loaded_q <= 1'b0;
      cal_write_q  <= 1'b0;
    end else begin
      cal_write_q <= 1'b0;
      if (!cal_loaded_q) begin
        cal_q        <= nv_cal_value;
        cal_loaded_q <= 1'b1;
      end else if (c.calibration_commit_cmd) begin
        cal_q       <= cal_q + 40'(steer_q);
        cal_write_q <= 1'b1;
      end
    end
  end
  assign cal_value = cal_q;
  assign cal_write = cal_write_q;

  // Mode bits, loaded from the store after reset release
  logic auto_q;
  logic disc_q;
  logic mode_loaded_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      auto_q        <= MODE_AUTO_RST;
      disc_q        <= MODE_DISC_RST;
      mode_loaded_q <= 1'b0;
    end else if (!mode_loaded_q) begin
      auto_q        <= nv_auto_align && !nv_discipline;
      disc_q        <= nv_discipline;
      mode_loaded_q <= 1'b1;
    end else if (c.set_auto_align) begin
      auto_q <= c.mode_value;
      if (c.mode_value) begin
        disc_q <= 1'b0;
      end
    end else if (c.set_discipline) begin
      disc_q <= c.mode_value;
      if (c.mode_value) begin
        auto_q <= 1'b0;
      end
    end
  end
  assign mode_auto_align = auto_q;
  assign mode_discipline = disc_q;

  // Pin synchronisers
  logic ref_lvl;
  tbsps_sync3 #(.RESET_VALUE(1'b0)) u_ref_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    (ref_pps_pin),
    .level  (ref_lvl)
  );

  // The timebase toggles on every clk, so two stages never agree on it;
  // its rising edge is read from stages two and three, at the cost of no glitch filter
  logic tb_s1_q;
  logic tb_s2_q;
  logic tb_s3_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tb_s1_q <= 1'b0;
      tb_s2_q <= 1'b0;
      tb_s3_q <= 1'b0;
    end else begin
      tb_s1_q <= tb_clk_pin;
      tb_s2_q <= tb_s1_q;
      tb_s3_q <= tb_s2_q;
    end
  end

  logic ref_prev_q;
  logic tb_rise;
  logic ref_rise;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_lvl;
    end
  end
  assign tb_rise  = tb_s2_q && !tb_s3_q;
  assign ref_rise = ref_lvl && !ref_prev_q;

  // Alignment control
  tbsps_align_t align_q;
  logic         align_hit;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      align_q <= TBSPS_ALIGN_IDLE;
    end else begin
      case (align_q)
        TBSPS_ALIGN_IDLE: begin
          if (auto_q) begin
            align_q <= TBSPS_ALIGN_AUTO;
          end else if (c.align_request) begin
            align_q <= TBSPS_ALIGN_ARMED;
          end
        end
        TBSPS_ALIGN_ARMED: begin
          if (auto_q) begin
            align_q <= TBSPS_ALIGN_AUTO;
          end else if (ref_rise) begin
            align_q <= TBSPS_ALIGN_IDLE;
          end
        end
        TBSPS_ALIGN_AUTO: begin
          if (!auto_q) begin
            align_q <= TBSPS_ALIGN_IDLE;
          end
        end
        default: begin
          align_q <= TBSPS_ALIGN_IDLE;
        end
      endcase
    end
  end
  // Idle manual state looks at nothing on the reference line
  assign align_hit = ref_rise && (align_q == TBSPS_ALIGN_ARMED
                                  || align_q == TBSPS_ALIGN_AUTO);

  // Pending alignment is honoured on the next timebase rising edge,
  // which is within one 100 ns period; that edge is the nearest one
  // seen after the reference, traded for no look-back buffering
  logic pend_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pend_q <= 1'b0;
    // A hit that meets a timebase edge restarts at once; pending would restart twice
    end else if (tb_rise) begin
      pend_q <= 1'b0;
    end else if (align_hit) begin
      pend_q <= 1'b1;
    end
  end

  // Divider, stepped only on timebase rising edges
  logic [PPS_CNT_W-1:0] div_q;
  logic                 pps_q;
  logic                 done_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q  <= '0;
      pps_q  <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tb_rise) begin
        if (pend_q || align_hit) begin
          div_q  <= '0;
          pps_q  <= 1'b1;
          done_q <= 1'b1;
        end else if (div_q == LAST_TICK) begin
          div_q <= '0;
          pps_q <= 1'b1;
        end else begin
          div_q <= div_q + 1'b1;
          if (div_q + 1'b1 == HIGH_TICKS) begin
            pps_q <= 1'b0;
          end
        end
      end
    end
  end
  assign pps_out    = pps_q;
  assign align_done = done_q;

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_STEER:  reg_rdata <= steer_q;
        ADDR_REPORT: reg_rdata <= report_q;
        ADDR_MODE:   reg_rdata <= {30'h0, disc_q, auto_q};
        ADDR_CAL_LO: reg_rdata <= cal_q[31:0];
        ADDR_STATUS: reg_rdata <= {29'h0, pps_q, align_q};
        default:     reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// File: testbench/tbsps_core_assertions.sv
/*
  Port checks for the steering and pulse-per-second core.
  Assumes a bind from the bench top and the same PPS_DIVIDE as the design.
*/
`timescale 1ns/10ps
module tbsps_core_assertions
  import tbsps_pkg::*;
#(
  parameter int unsigned PPS_DIVIDE = PPS_DIV
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // Host side
  input wire logic [3:0]            reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire tbsps_pkg::tbsps_cmd_t cmd,
  // Results
  input wire logic signed [39:0]    cal_value,
  input wire logic                  cal_write,
  input wire logic                  mode_auto_align,
  input wire logic                  mode_discipline,
  input wire logic signed [31:0]    steer_total,
  input wire logic signed [31:0]    steer_report,
  input wire logic                  ref_pps_pin,
  input wire logic                  pps_out,
  input wire logic                  align_done
);
  logic        armed_q;
  logic        seen_q;
  int unsigned tick_q;

  function automatic logic signed [31:0] sat(input longint v);
    return (v > STEER_LIMIT) ? STEER_LIMIT : (v < -STEER_LIMIT) ? -STEER_LIMIT : 32'(v);
  endfunction

  function automatic logic signed [31:0] rnd(input logic signed [31:0] s);
    return (s < 0) ? -((REPORT_HALF - s) / REPORT_DIV) : (s + REPORT_HALF) / REPORT_DIV;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Pending manual request, dropped once an alignment lands
  always_ff @(posedge clk) begin
    if (!resetn) begin
      armed_q <= 1'b0;
    end else if (cmd.align_request || (reg_wr && reg_addr == 4'h2 && reg_wdata[3])) begin
      armed_q <= 1'b1;
    end else if (align_done) begin
      armed_q <= 1'b0;
    end
  end

  // Cycles since the last period start; phase unknown until one is seen
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_q <= 0;
      seen_q <= 1'b0;
    end else if ($rose(pps_out) || align_done) begin
      tick_q <= 0;
      seen_q <= 1'b1;
    end else begin
      tick_q <= tick_q + 1;
    end
  end

  AST_ABS: assert property (
    cmd.absolute_adjust_cmd && !cmd.calibration_commit_cmd && !reg_wr
    |=> steer_total == sat($past(cmd.value))) else $error("Absolute steer mismatch");
  AST_REL: assert property (
    cmd.relative_adjust_cmd && !cmd.absolute_adjust_cmd && !cmd.calibration_commit_cmd && !reg_wr
    |=> steer_total == sat(longint'($past(steer_total)) + sat($past(cmd.value))))
    else $error("Relative steer mismatch");
  AST_COMMIT: assert property (
    cmd.calibration_commit_cmd |=> cal_write && steer_total == 0
    && cal_value == $past(cal_value) + $past(steer_total)) else $error("Commit mismatch");
  AST_REPORT: assert property (
    steer_report == rnd($past(steer_total))) else $error("Report rounding mismatch");
  AST_RESET: assert property (disable iff (1'b0)
    !resetn |=> steer_total == 0 && steer_report == 0 && pps_out && !cal_write)
    else $error("Reset state wrong");
  AST_PERIOD: assert property (
    seen_q && $rose(pps_out) && !align_done |-> tick_q == 2 * PPS_DIVIDE - 1)
    else $error("Pulse period wrong");
  AST_HIGH: assert property (
    seen_q && $fell(pps_out) |-> tick_q == PPS_DIVIDE - 1) else $error("Pulse high time wrong");
  AST_MANUAL: assert property (
    align_done |-> mode_auto_align || armed_q) else $error("Alignment without request");
  AST_REQ: assert property (
    armed_q && !mode_auto_align && $rose(ref_pps_pin) |-> ##[1:12] align_done)
    else $error("Requested alignment missing");
  AST_AUTO: assert property (
    mode_auto_align && $rose(ref_pps_pin) |-> ##[1:12] align_done && pps_out)
    else $error("Automatic alignment missing");
  AST_EXCL: assert property (
    !(mode_auto_align && mode_discipline)) else $error("Both modes enabled");
  AST_MODE: assert property (
    cmd.set_auto_align && cmd.mode_value && !reg_wr |=> mode_auto_align && !mode_discipline)
    else $error("Auto mode not set");
endmodule

// File: testbench/tbsps_far_end.sv
/*
  Far side model: free-running 10 MHz timebase and a reference pulse source.
  Assumes clk at 20 MHz; fire is a one-cycle request from the bench.
*/
`timescale 1ns/10ps
module tbsps_far_end (
  // Clock and trigger
  input  wire logic clk,
  input  wire logic fire,
  // Pins toward the core
  output logic      tb_clk_pin,
  output logic      ref_pps_pin
);
  int unsigned hold_q = 0;

  initial begin
    tb_clk_pin  = 1'b0;
    ref_pps_pin = 1'b0;
  end

  // Runs from power-up, lock or not
  always @(posedge clk) begin
    tb_clk_pin <= !tb_clk_pin;
  end

  // Pulse wide enough to survive the synchroniser
  always @(posedge clk) begin
    hold_q      <= fire ? 7 : (hold_q != 0) ? hold_q - 1 : 0;
    ref_pps_pin <= fire || hold_q != 0;
  end
endmodule

// File: testbench/tb.sv
/*
  Self-checking bench for the steering and pulse core.
  Assumes the far side model and a divider shortened to 10 ticks.
*/
`timescale 1ns/10ps
module tb;
  import tbsps_pkg::*;
  localparam int unsigned PPS_DIVIDE = 10;
  logic               clk, resetn, reg_wr, reg_rd, fire, tb_clk_pin, ref_pps_pin, last;
  logic               nv_auto_align, nv_discipline, cal_write, pps_out, align_done;
  logic               mode_auto_align, mode_discipline;
  logic [3:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata, d;
  logic signed [31:0] steer_total, steer_report, exp_steer, v;
  logic signed [39:0] nv_cal_value, cal_value, exp_cal;
  tbsps_cmd_t         cmd;
  int                 failures, comparisons, cycles, aligns, a, n, k;
  integer             seed;

  tbsps_core #(.PPS_DIVIDE(PPS_DIVIDE)) u_tbsps_core (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd(cmd), .nv_cal_value(nv_cal_value),
    .nv_auto_align(nv_auto_align), .nv_discipline(nv_discipline), .cal_value(cal_value),
    .cal_write(cal_write), .mode_auto_align(mode_auto_align),
    .mode_discipline(mode_discipline), .steer_total(steer_total),
    .steer_report(steer_report), .tb_clk_pin(tb_clk_pin), .ref_pps_pin(ref_pps_pin),
    .pps_out(pps_out), .align_done(align_done));
  tbsps_far_end u_tbsps_far_end (.clk(clk), .fire(fire), .tb_clk_pin(tb_clk_pin),
    .ref_pps_pin(ref_pps_pin));

  function automatic logic signed [31:0] sat(input longint x);
    return (x > STEER_LIMIT) ? STEER_LIMIT : (x < -STEER_LIMIT) ? -STEER_LIMIT : 32'(x);
  endfunction
  function automatic logic signed [31:0] rnd(input logic signed [31:0] s);
    return (s < 0) ? -((32'sd500 - s) / 32'sd1000) : (s + 32'sd500) / 32'sd1000;
  endfunction

  task automatic report_and_stop();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] ad, input logic [31:0] wd);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [3:0] ad, output logic [31:0] rd);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  // Kinds: 0 absolute, 1 relative, 2 commit, 3 align, 4 auto on, 5 discipline on
  task automatic pulse(input int kind, input logic signed [31:0] val);
    tbsps_cmd_t c;
    c = '0;
    c.absolute_adjust_cmd    = kind == 0;
    c.relative_adjust_cmd    = kind == 1;
    c.calibration_commit_cmd = kind == 2;
    c.align_request          = kind == 3;
    c.set_auto_align         = kind == 4;
    c.set_discipline         = kind == 5;
    c.mode_value             = kind >= 4;
    c.value                  = val;
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask
  task automatic fire_ref(input int gap);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (gap) @(posedge clk);
    #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    aligns += align_done;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    seed = 32'h2dd0326f;
    {resetn, reg_wr, reg_rd, fire, nv_auto_align} = '0;
    {reg_addr, reg_wdata, cmd} = '0;
    nv_discipline = 1'b1;
    nv_cal_value  = 40'hff00001234;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    exp_cal   = nv_cal_value;
    exp_steer = 0;
    check(cal_value, exp_cal, "cal load");
    check(steer_total, 0, "steer after reset");
    for (int i = 0; i < 40; i++) begin
      k = (i < 6) ? 1 : $random(seed) & 1;
      v = (i < 3) ? 32'sh7fffffff : (i < 6) ? 32'sh80000000 : $random(seed) % 32'sd30000000;
      exp_steer = k == 0 ? sat(v) : sat(longint'(exp_steer) + sat(v));
      if (i % 4 == 3) reg_write(k[3:0], v);
      else pulse(k, v);
      check(steer_total, exp_steer, "steer");
      reg_read(4'h1, d);
      check(d, unsigned'(rnd(exp_steer)), "report");
    end
    // Commits kept rare to spare the store
    exp_cal = exp_cal + exp_steer;
    pulse(2, 32'sd5);
    check(cal_write, 1'b1, "store write");
    check(cal_value, exp_cal, "cal sum");
    check(steer_total, 0, "steer cleared");
    pulse(1, -32'sd1234567);
    exp_cal = exp_cal - 40'sd1234567;
    reg_write(4'h2, 32'h10);
    reg_read(4'h3, d);
    check(d, exp_cal[31:0], "cal readback");
    reg_read(4'hf, d);
    check(d, 0, "unmapped read");
    reg_write(4'he, $random(seed));
    check(steer_total, 0, "unmapped write");
    a = aligns;
    fire_ref(30);
    check(aligns, a, "manual ignores ref");
    pulse(3, 0);
    repeat (4) @(posedge clk);
    fire_ref(30);
    check(aligns, a + 1, "requested align");
    n = 0;
    last = pps_out;
    repeat (200) begin
      @(posedge clk);
      #1;
      n += pps_out && !last;
      last = pps_out;
    end
    check(n, 10, "pulse count");
    reg_write(4'h2, 32'h5);
    reg_read(4'h2, d);
    check(d, 32'h1, "auto mode");
    reg_write(4'h2, 32'h6);
    reg_read(4'h2, d);
    check(d, 32'h2, "discipline mode");
    pulse(4, 0);
    a = aligns;
    fire_ref(40);
    fire_ref(40);
    check(aligns, a + 2, "auto align");
    pulse(0, 32'sd777000);
    // Store keeps what the core last held before power drops
    @(posedge clk);
    resetn        <= 1'b0;
    nv_cal_value  <= cal_value;
    nv_auto_align <= mode_auto_align;
    nv_discipline <= mode_discipline;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(steer_total, 0, "steer volatile");
    check({mode_discipline, mode_auto_align}, 2'b01, "mode reload");
    check(cal_value, exp_cal, "cal kept");
    report_and_stop();
  end
endmodule

bind tbsps_core tbsps_core_assertions #(.PPS_DIVIDE(PPS_DIVIDE)) u_tbsps_core_assertions (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .cmd(cmd), .cal_value(cal_value), .cal_write(cal_write), .mode_auto_align(mode_auto_align),
  .mode_discipline(mode_discipline), .steer_total(steer_total),
  .steer_report(steer_report), .ref_pps_pin(ref_pps_pin), .pps_out(pps_out),
  .align_done(align_done));
